// ---- design/mamcd_top.sv ----
/*
  Amplifier MIDI control decoder: channel filter, controller decoding, silence
  interlock, preset store, status LED patterns and an Avalon-MM register port.
  Assumes all inputs synchronous to clk_sys and switches already debounced.
*/
// Implementation choices: the address map and register access over Avalon-MM.
// Contract
// - Accept messages on selected channel or omni.
// - Mode switch off selects omni reception.
// - Channel equals switches two-to-five value plus one.
// - Controllers act only when enable switch on.
// - Fixed controller table maps eight functions.
// - Values below five off, five up on.
// - Controllers 7 and 28 inverted silence.
// - Standby keeps silence, ignores all releases.
// - Preset stores standby state as silence.
// - Standby change marks preset modified, flashes.
// - No speaker load keeps power stage off.
// - Standby on without load: fast flash.
// - Tube fault gives repeated one-to-four flash bursts.
// - Tube faults reported only with stage active.
// - Brief standby press clears tube fault.
// - Every input byte copied to thru.
// - Preset one applied before any message; reset clears q.pvalid first, so preset one is never loaded at start-up.
// - Controller 14 selects output level.
// - Footswitch presence blocks MIDI input.
`timescale 1ns/1ns
module mamcd_top
  import mamcd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             thru_valid,
  output logic [7:0]       thru_byte,
  input  wire logic        channel_mode_switch,
  input  wire logic        channel_bit3_switch,
  input  wire logic        channel_bit2_switch,
  input  wire logic        channel_bit1_switch,
  input  wire logic        channel_bit0_switch,
  input  wire logic        controller_enable_switch,
  input  wire logic        standby_on,
  input  wire logic [2:0]  load_sense,
  input  wire logic [3:0]  tube_fault,
  input  wire logic        footswitch_present,
  input  wire logic        fs_mute_valid,
  input  wire logic        fs_mute_on,
  output logic             tone_on,
  output logic             fx_loop_sel,
  output logic             noise_gate_on,
  output logic             high_gain_on,
  output logic             low_mid_on,
  output logic             high_mid_on,
  output logic             level_sel_b,
  output logic             power_stage_en,
  output logic             status_led
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic                    init;
    logic [FUNC_W-1:0]       func;
    logic                    mute_req;
    logic                    standby_q;
    logic                    modified;
    logic [6:0]              preset;
    logic [PRESET_COUNT-1:0] pvalid;
    logic [2:0]              tube_id;
    logic [TW-1:0]           tick_cnt;
    logic [3:0]              sub;
    logic [3:0]              slot;
    logic [7:0]              stby_ticks;
    logic                    ack;
    logic [31:0]             rdata;
    logic [13:0]             last_cc;
    logic                    led;
  } mamcd_state_s;

  mamcd_state_s q;
  mamcd_state_s next_q;
  logic [FUNC_W:0] pmem [PRESET_COUNT];

  logic       ev_cc;
  logic       ev_pc;
  logic [3:0] ev_chan;
  logic [6:0] ev_num;
  logic [6:0] ev_val;
  logic [3:0] chan_sel;
  logic       chan_match;
  logic       ev_ok;
  logic       load_present;
  logic       preset_we;

  //////////////////////////////////////////////////////////////////////////////

  mamcd_midi_parser u_parser (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .ce         (ce),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .thru_valid (thru_valid),
    .thru_byte  (thru_byte),
    .ev_cc      (ev_cc),
    .ev_pc      (ev_pc),
    .ev_chan    (ev_chan),
    .ev_num     (ev_num),
    .ev_val     (ev_val)
  );

  // Returns one-hot function select for an ordinary controller number.
  function automatic logic [FUNC_W-1:0] cc_func_sel(input logic [6:0] num);
    logic [FUNC_W-1:0] sel;
    sel = '0;
    case (num)
      CC_TONE:   sel[F_TONE]   = 1'b1;
      CC_FXLOOP: sel[F_FXLOOP] = 1'b1;
      CC_GATE:   sel[F_GATE]   = 1'b1;
      CC_HIGAIN: sel[F_HIGAIN] = 1'b1;
      CC_LOMID:  sel[F_LOMID]  = 1'b1;
      CC_HIMID:  sel[F_HIMID]  = 1'b1;
      CC_LEVEL:  sel[F_LEVEL]  = 1'b1;
      default:   sel = '0;
    endcase
    return sel;
  endfunction : cc_func_sel

  // Lowest failing tube gives the burst length, 1 to 4.
  function automatic logic [2:0] first_fault(input logic [3:0] f);
    logic [2:0] id;
    id = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (f[i]) begin
        id = 3'(i + 1);
      end
    end
    return id;
  endfunction : first_fault

  assign chan_sel = {channel_bit3_switch, channel_bit2_switch,
                     channel_bit1_switch, channel_bit0_switch};
  assign chan_match   = !channel_mode_switch || (ev_chan == chan_sel);
  assign ev_ok        = !q.init && !footswitch_present && chan_match;
  assign load_present = |load_sense;
  assign power_stage_en = q.standby_q && load_present && !q.mute_req && !q.init;
  assign preset_we = ce && avs_write && q.ack && (avs_address == OFS_CTRL)
                     && avs_byteenable[0] && avs_writedata[CTRL_WRITE_PRESET] && !q.init;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic              tick;
    logic              do_apply;
    logic [6:0]        pidx;
    logic [FUNC_W:0]   pword;
    logic [FUNC_W-1:0] sel;
    logic              val_on;
    tick     = 1'b0;
    do_apply = 1'b0;
    pidx     = 7'h00;
    pword    = '0;
    sel      = '0;
    val_on   = (ev_val >= VAL_ON_MIN);
    next_q   = q;

    // Timebase for LED patterns and standby press length.
    if (q.tick_cnt == TICK_LAST) begin
      next_q.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 1'b1;
    end
    if (tick) begin
      if (q.sub == SLOT_TICKS - 4'h1) begin
        next_q.sub  = 4'h0;
        next_q.slot = q.slot + 4'h1;
      end else begin
        next_q.sub = q.sub + 4'h1;
      end
      if (!standby_on && q.stby_ticks != STBY_TICKS_MAX) begin
        next_q.stby_ticks = q.stby_ticks + 8'h01;
      end
    end

    // Bus: each request waits one cycle; read data is latched on the first.
    next_q.ack = (avs_read || avs_write) && !q.ack;
    if (avs_read && !q.ack) begin
      case (avs_address)
        OFS_CTRL:   next_q.rdata = {25'h0, q.preset};
        OFS_STATUS: next_q.rdata = {16'h0, q.led, q.tube_id, q.init, q.modified,
                                    load_present, power_stage_en, q.mute_req, q.func};
        OFS_LASTCC: next_q.rdata = {17'h0, q.last_cc[13:7], 1'b0, q.last_cc[6:0]};
        default:    next_q.rdata = 32'h0;
      endcase
    end
    if (avs_write && q.ack && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      if (avs_writedata[CTRL_CLR_MODIFIED]) begin
        next_q.modified = 1'b0;
      end
      if (preset_we) begin
        next_q.pvalid[q.preset] = 1'b1;
        next_q.modified = 1'b0;
      end
    end

    // Standby edges: edit mark, silence release and tube fault clearing.
    // The edge register resets low whatever the switch says; the q.init gate keeps the start-up cycle from counting as an edge.
    next_q.standby_q = standby_on;
    if (!q.init && standby_on != q.standby_q) begin
      next_q.modified = 1'b1;
      if (standby_on) begin
        next_q.mute_req = 1'b0;
        if (q.stby_ticks < BRIEF_TICKS) begin
          next_q.tube_id = 3'h0;
        end
      end else begin
        next_q.stby_ticks = 8'h00;
      end
    end

    // Preset one at start-up, or a received program change.
    if (q.init) begin
      next_q.init = 1'b0;
      do_apply = 1'b1;
    end else if (ev_ok && ev_pc) begin
      next_q.preset = ev_num;
      pidx = ev_num;
      do_apply = 1'b1;
    end
    pword = pmem[pidx];
    if (do_apply && q.pvalid[pidx]) begin
      next_q.func = pword[FUNC_W-1:0];
      if (pword[FUNC_W]) begin
        next_q.mute_req = 1'b1;
      end else if (standby_on) begin
        next_q.mute_req = 1'b0;
      end
    end

    // Controller messages.
    if (ev_ok && ev_cc && controller_enable_switch) begin
      next_q.last_cc = {ev_val, ev_num};
      if (ev_num == CC_MUTE_A || ev_num == CC_MUTE_B) begin
        if (!val_on) begin
          next_q.mute_req = 1'b1;
        end else if (standby_on) begin
          next_q.mute_req = 1'b0;
        end
      end else begin
        sel = cc_func_sel(ev_num);
        next_q.func = val_on ? (q.func | sel) : (q.func & ~sel);
      end
    end

    // Serial footswitch silence command.
    if (fs_mute_valid && !q.init) begin
      if (fs_mute_on) begin
        next_q.mute_req = 1'b1;
      end else if (standby_on) begin
        next_q.mute_req = 1'b0;
      end
    end
    if (!standby_on) begin
      next_q.mute_req = 1'b1;
    end

    // Tube monitor latches only while the stage runs.
    if (power_stage_en && q.tube_id == 3'h0 && |tube_fault) begin
      next_q.tube_id = first_fault(tube_fault);
    end

    // Status LED, highest priority first.
    if (q.standby_q && !load_present && !q.init) begin
      next_q.led = (q.sub < FAST_HALF_TICKS);
    end else if (power_stage_en && q.tube_id != 3'h0) begin
      next_q.led = q.slot[0] && ({1'b0, q.slot[3:1]} < {1'b0, q.tube_id});
    end else if (q.modified) begin
      next_q.led = q.slot[2];
    end else begin
      next_q.led = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q      <= '0;
      q.init <= 1'b1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // Preset memory; the silence bit holds the inverted standby state.
  always_ff @(posedge clk_sys) begin
    if (preset_we) begin
      pmem[q.preset] <= {!standby_on, q.func};
    end
  end

  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign tone_on         = q.func[F_TONE];
  assign fx_loop_sel     = q.func[F_FXLOOP];
  assign noise_gate_on   = q.func[F_GATE];
  assign high_gain_on    = q.func[F_HIGAIN];
  assign low_mid_on      = q.func[F_LOMID];
  assign high_mid_on     = q.func[F_HIMID];
  assign level_sel_b     = q.func[F_LEVEL];
  assign status_led      = q.led;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_rd_req;
    ce && avs_read && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    !avs_waitrequest && avs_read;
  endsequence
  sequence s_brief_off;
    ce && !standby_on && q.standby_q ##1 (!standby_on)[*2];
  endsequence

  chk_bus_wait: assert property (s_rd_req ##1 avs_read |-> s_rd_done)
    else $error("read not answered after one wait cycle");
  chk_chan_filter: assert property (ce && ev_cc && channel_mode_switch
    && ev_chan != chan_sel |=> $stable(q.func))
    else $error("message on foreign channel changed a function");
  chk_omni_tone: assert property (ce && ev_cc && !q.init && !channel_mode_switch
    && !footswitch_present && controller_enable_switch && ev_num == CC_TONE
    |=> q.func[F_TONE] == ($past(ev_val) >= 7'h05))
    else $error("omni tone controller not applied with threshold five");
  chk_cc_disabled: assert property (ce && ev_cc && !controller_enable_switch
    && !ev_pc |=> $stable(q.func))
    else $error("controller acted while disabled");
  chk_cc_mute: assert property (ce && ev_ok && ev_cc && controller_enable_switch
    && ev_num == CC_MUTE_B && ev_val < 7'h05 |=> q.mute_req)
    else $error("low value on silence controller did not engage silence");
  chk_standby_hold: assert property (ce && !standby_on |=> q.mute_req && !power_stage_en)
    else $error("silence released while standby engaged");
  chk_no_load: assert property (!load_present |-> !power_stage_en)
    else $error("power stage enabled without load");
  chk_fast_flash: assert property (ce && q.standby_q && !load_present && !q.init
    |=> status_led == ($past(q.sub) < 4'h5))
    else $error("fast flash pattern wrong without load");
  chk_tube_gate: assert property (ce && !power_stage_en && q.tube_id == 3'h0
    |=> q.tube_id == 3'h0)
    else $error("tube fault latched with stage inactive");
  chk_brief_clear: assert property (s_brief_off ##1 (ce && standby_on
    && q.stby_ticks < 8'h32) |=> q.tube_id == 3'h0)
    else $error("brief standby press did not clear tube fault");
  chk_thru_copy: assert property (ce && rx_valid
    |=> thru_valid && thru_byte == $past(rx_byte))
    else $error("input byte not copied to thru");
  chk_init_apply: assert property (ce && q.init |=> !q.init ##0 (!q.pvalid[0]
    || q.func == $past(pmem[0][FUNC_W-1:0])))
    else $error("preset one not applied at start-up");
  chk_fs_block: assert property (ce && footswitch_present && !q.init
    |=> $stable(q.func) && $stable(q.preset))
    else $error("MIDI acted while footswitch present");

endmodule : mamcd_top

// ---- design/mamcd_pkg.sv ----
/*
  Constants shared by the amplifier MIDI control decoder: bus offsets, status
  field positions, controller numbers, function bit positions and LED timing.
  Assumes a 50 MHz system clock and a 32-bit Avalon-MM slave port.
*/
package mamcd_pkg;

  // Clock and timing base.
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned TICK_US         = 10000;
  localparam int unsigned TICK_CYC        = TICK_US * CLK_MHZ;
  localparam logic [3:0]  SLOT_TICKS      = 4'hA;
  localparam logic [3:0]  FAST_HALF_TICKS = 4'h5;
  localparam logic [7:0]  BRIEF_TICKS     = 8'h32;
  localparam logic [7:0]  STBY_TICKS_MAX  = 8'hFF;

  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LASTCC = 4'h8;

  // Control register bits.
  localparam int CTRL_WRITE_PRESET = 0;
  localparam int CTRL_CLR_MODIFIED = 1;

  // Status register fields.
  localparam int ST_FUNC_LSB  = 0;
  localparam int ST_MUTE      = 7;
  localparam int ST_STAGE_EN  = 8;
  localparam int ST_LOAD      = 9;
  localparam int ST_MODIFIED  = 10;
  localparam int ST_INIT      = 11;
  localparam int ST_TUBE_LSB  = 12;
  localparam int ST_LED       = 15;
  localparam int LASTCC_VAL_LSB = 8;

  // Function bit positions.
  localparam int F_TONE   = 0;
  localparam int F_FXLOOP = 1;
  localparam int F_GATE   = 2;
  localparam int F_HIGAIN = 3;
  localparam int F_LOMID  = 4;
  localparam int F_HIMID  = 5;
  localparam int F_LEVEL  = 6;
  localparam int FUNC_W   = 7;

  // Controller numbers.
  localparam logic [6:0] CC_MUTE_A = 7'h07;
  localparam logic [6:0] CC_LEVEL  = 7'h0E;
  localparam logic [6:0] CC_TONE   = 7'h16;
  localparam logic [6:0] CC_FXLOOP = 7'h17;
  localparam logic [6:0] CC_GATE   = 7'h18;
  localparam logic [6:0] CC_HIGAIN = 7'h1B;
  localparam logic [6:0] CC_MUTE_B = 7'h1C;
  localparam logic [6:0] CC_LOMID  = 7'h1D;
  localparam logic [6:0] CC_HIMID  = 7'h1E;
  localparam logic [6:0] VAL_ON_MIN = 7'h05;

  // MIDI status nibbles and boundaries.
  localparam logic [3:0] ST_NIB_CC   = 4'hB;
  localparam logic [3:0] ST_NIB_PC   = 4'hC;
  localparam logic [3:0] ST_NIB_CP   = 4'hD;
  localparam logic [7:0] SYS_FIRST   = 8'hF0;
  localparam logic [7:0] RT_FIRST    = 8'hF8;

  localparam int unsigned PRESET_COUNT = 128;

endpackage : mamcd_pkg

// ---- design/mamcd_midi_parser.sv ----
/*
  MIDI byte parser: copies every input byte to the thru output and extracts
  controller and program change events with running status.
  Assumes received bytes arrive as one-cycle strobes synchronous to clk_sys.
*/
`timescale 1ns/1ns
module mamcd_midi_parser
  import mamcd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  output logic            thru_valid,
  output logic [7:0]      thru_byte,
  output logic            ev_cc,
  output logic            ev_pc,
  output logic [3:0]      ev_chan,
  output logic [6:0]      ev_num,
  output logic [6:0]      ev_val
);

  typedef struct packed {
    logic       thru_valid;
    logic [7:0] thru_byte;
    logic [7:0] status;
    logic       have1;
    logic [6:0] data1;
    logic       ev_cc;
    logic       ev_pc;
    logic [3:0] ev_chan;
    logic [6:0] ev_num;
    logic [6:0] ev_val;
  } mamcd_parse_s;

  mamcd_parse_s q;
  mamcd_parse_s next_q;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_q            = q;
    next_q.ev_cc      = 1'b0;
    next_q.ev_pc      = 1'b0;
    next_q.thru_valid = rx_valid;
    if (rx_valid) begin
      next_q.thru_byte = rx_byte;
      if (rx_byte[7]) begin
        // Real-time bytes may interleave and leave running status alone.
        if (rx_byte < RT_FIRST) begin
          next_q.have1  = 1'b0;
          next_q.status = (rx_byte >= SYS_FIRST) ? 8'h00 : rx_byte;
        end
      end else if (q.status[7]) begin
        if (q.status[7:4] == ST_NIB_PC) begin
          next_q.ev_pc   = 1'b1;
          next_q.ev_chan = q.status[3:0];
          next_q.ev_num  = rx_byte[6:0];
        end else if (q.status[7:4] != ST_NIB_CP) begin
          if (!q.have1) begin
            next_q.have1 = 1'b1;
            next_q.data1 = rx_byte[6:0];
          end else begin
            next_q.have1   = 1'b0;
            next_q.ev_cc   = (q.status[7:4] == ST_NIB_CC);
            next_q.ev_chan = q.status[3:0];
            next_q.ev_num  = q.data1;
            next_q.ev_val  = rx_byte[6:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign thru_valid = q.thru_valid;
  assign thru_byte  = q.thru_byte;
  assign ev_cc      = q.ev_cc;
  assign ev_pc      = q.ev_pc;
  assign ev_chan    = q.ev_chan;
  assign ev_num     = q.ev_num;
  assign ev_val     = q.ev_val;

endmodule : mamcd_midi_parser

// ---- testbench/mamcd_midi_src.sv ----
/*
  Model of the MIDI sender that drives the decoder's receive strobe and byte.
  Assumes its tasks are called by the bench right after a rising clock edge.
*/
`timescale 1ns/1ns
module mamcd_midi_src
  import mamcd_pkg::*;
(
  input  wire logic clk_sys,
  output logic      rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'hA5;
  end

  // Between bytes the data lines carry the inverse, so nothing stale looks valid.
  task automatic send_byte(input logic [7:0] b, input int gap);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    repeat (gap) @(posedge clk_sys);
  endtask : send_byte

  // A controller message is sent whole: status, number, value.
  task automatic send_cc(input logic [3:0] ch, input logic [6:0] num,
                         input logic [6:0] val, input int gap);
    send_byte({ST_NIB_CC, ch}, gap);
    send_byte({1'b0, num}, gap);
    send_byte({1'b0, val}, gap);
  endtask : send_cc

  // A program change carries one data byte.
  task automatic send_pc(input logic [3:0] ch, input logic [6:0] num, input int gap);
    send_byte({ST_NIB_PC, ch}, gap);
    send_byte({1'b0, num}, gap);
  endtask : send_pc
endmodule : mamcd_midi_src

// ---- testbench/midi_amp_control_decoder_tb.sv ----
/*
  Self-checking bench: channel filter, controller table, silence interlock,
  thru copy, LED and status registers.
  Assumes the package, the design and the sender model are compiled first.
*/
`timescale 1ns/1ns
module midi_amp_control_decoder_tb;
  import mamcd_pkg::*;
  logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, rx_valid, thru_valid;
  logic controller_enable_switch, standby_on, footswitch_present, fs_mute_valid;
  logic fs_mute_on, tone_on, fx_loop_sel, noise_gate_on, high_gain_on, low_mid_on;
  logic high_mid_on, level_sel_b, power_stage_en, status_led;
  logic [3:0]  avs_address, tube_fault;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  rx_byte, thru_byte, q[$];
  logic [2:0]  load_sense;
  logic [4:0]  chsw;
  logic [6:0]  fn, ef;
  int          failures, comparisons;
  assign fn = {level_sel_b, high_mid_on, low_mid_on, high_gain_on, noise_gate_on,
               fx_loop_sel, tone_on};

  mamcd_top #(.TICK_CYCLES(4)) dut_u (
    .clk_sys, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .rx_valid, .rx_byte,
    .thru_valid, .thru_byte, .channel_mode_switch(chsw[4]),
    .channel_bit3_switch(chsw[3]), .channel_bit2_switch(chsw[2]),
    .channel_bit1_switch(chsw[1]), .channel_bit0_switch(chsw[0]),
    .controller_enable_switch, .standby_on, .load_sense, .tube_fault,
    .footswitch_present, .fs_mute_valid, .fs_mute_on, .tone_on, .fx_loop_sel,
    .noise_gate_on, .high_gain_on, .low_mid_on, .high_mid_on, .level_sel_b,
    .power_stage_en, .status_led);
  mamcd_midi_src src_u (.clk_sys, .rx_valid, .rx_byte);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
    @(posedge clk_sys);
  endtask : bus

  task automatic cc(input logic [3:0] ch, input logic [6:0] num, input logic [6:0] val);
    src_u.send_cc(ch, num, val, int'($urandom_range(1, 3)));
    repeat (4) @(posedge clk_sys);
  endtask : cc

  // Every received byte must reappear on thru, in order.
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) q.push_back(rx_byte);
    if (thru_valid === 1'b1) check({24'h0, thru_byte}, q.size() ? q.pop_front() : 8'hXX);
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    finish_test();
  end

  initial begin
    logic [6:0]  tab [7];
    logic [3:0]  ch;
    logic [6:0]  v;
    logic [31:0] r;
    int          k, t;
    tab = '{CC_TONE, CC_FXLOOP, CC_GATE, CC_HIGAIN, CC_LOMID, CC_HIMID, CC_LEVEL};
    void'($urandom(80073));
    {srst, avs_read, avs_write, fs_mute_valid, fs_mute_on, footswitch_present} = 6'h20;
    {avs_address, avs_writedata, tube_fault, load_sense} = '0;
    chsw = 5'h00;
    controller_enable_switch = 1'b1;
    standby_on = 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    load_sense <= 3'h1;
    ch = 4'($urandom_range(0, 15));
    chsw <= {1'b1, ch};
    repeat (4) @(posedge clk_sys);
    cc(ch, CC_TONE, 7'h7F);
    check(tone_on, 1'b1);
    cc(ch + 4'h1, CC_TONE, 7'h00);
    check(tone_on, 1'b1);
    chsw <= 5'h0F;
    cc(ch + 4'h1, CC_TONE, 7'h00);
    check(tone_on, 1'b0);
    ef = 7'h00;
    for (int i = 0; i < 34; i++) begin
      k = i % 7;
      v = (i < 7) ? 7'h05 : (i < 14) ? 7'h04 : 7'($urandom_range(0, 127));
      ef[k] = (v >= 7'h05);
      cc(4'($urandom_range(0, 15)), tab[k], v);
      check(fn, ef);
    end
    controller_enable_switch <= 1'b0;
    cc(ch, tab[0], ef[0] ? 7'h00 : 7'h7F);
    check(fn, ef);
    controller_enable_switch <= 1'b1;
    footswitch_present <= 1'b1;
    cc(ch, tab[1], ef[1] ? 7'h00 : 7'h7F);
    check(fn, ef);
    footswitch_present <= 1'b0;
    cc(ch, CC_MUTE_A, 7'h7F);
    check(power_stage_en, 1'b1);
    cc(ch, CC_MUTE_B, 7'h00);
    check(power_stage_en, 1'b0);
    cc(ch, CC_MUTE_B, 7'h05);
    check(power_stage_en, 1'b1);
    standby_on <= 1'b0;
    cc(ch, CC_MUTE_A, 7'h7F);
    check(power_stage_en, 1'b0);
    fs_mute_valid <= 1'b1;
    @(posedge clk_sys);
    fs_mute_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(power_stage_en, 1'b0);
    standby_on <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(power_stage_en, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check(r[ST_STAGE_EN], 1'b1);
    check(r[ST_MODIFIED], 1'b1);
    bus(1'b1, OFS_CTRL, 32'h2, r);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check(r[ST_MODIFIED], 1'b0);
    bus(1'b0, 4'hC, 32'h0, r);
    check(r, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1, r);
    cc(ch, tab[0], ef[0] ? 7'h00 : 7'h7F);
    src_u.send_pc(ch, 7'h00, 1);
    repeat (4) @(posedge clk_sys);
    check(fn, ef);
    standby_on <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h1, r);
    standby_on <= 1'b1;
    src_u.send_pc(ch, 7'h00, 1);
    repeat (4) @(posedge clk_sys);
    check(power_stage_en, 1'b0);
    cc(ch, CC_MUTE_A, 7'h7F);
    check(power_stage_en, 1'b1);
    bus(1'b0, OFS_LASTCC, 32'h0, r);
    check(r, (32'h7F << LASTCC_VAL_LSB) | 32'(CC_MUTE_A));
    load_sense <= 3'h0;
    tube_fault <= 4'h2;
    repeat (3) @(posedge clk_sys);
    check(power_stage_en, 1'b0);
    t = 0;
    for (int i = 0; i < 100; i++) begin
      v[0] = status_led;
      @(posedge clk_sys);
      if (status_led !== v[0]) t++;
    end
    check(t >= 4, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check(r[14:12], 3'h0);
    load_sense <= 3'h4;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check(r[14:12], 3'h2);
    // One full burst cycle: 16 slots of 10 ticks of 4 clocks.
    t = 0;
    for (int i = 0; i < 640; i++) begin
      v[0] = status_led;
      @(posedge clk_sys);
      if (status_led === 1'b1 && v[0] === 1'b0) t++;
    end
    check(t, 2);
    tube_fault <= 4'h0;
    standby_on <= 1'b0;
    repeat (3) @(posedge clk_sys);
    standby_on <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h0, r);
    check(r[14:12], 3'h0);
    finish_test();
  end
endmodule : midi_amp_control_decoder_tb
